// >>> shared/fbl_pkg.sv
// Shared constants, register map and state types for the flash boot autobaud loader
package fbl_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_ERASE_BLK = 8'h08;
  localparam logic [7:0] REG_SERIAL_CTRL = 8'h0C;
  localparam logic [7:0] REG_LOAD_COUNT = 8'h10;

  // Mode pin encodings as sampled (boot uses the inverted top pin)
  localparam logic [2:0] MODE_BOOT5 = 3'h1;
  localparam logic [2:0] MODE_BOOT7 = 3'h3;
  localparam logic [2:0] MODE_USER5 = 3'h5;
  localparam logic [2:0] MODE_USER7 = 3'h7;

  // Serial bytes of the handshake
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_CONFIRM = 8'h55;

  // Branch target of the loaded program
  localparam logic [19:0] RAM_START_ADDR = 20'hFF300;

  // Bits timed during a zero byte: start bit plus eight data bits
  localparam int unsigned LOW_BITS = 9;
  localparam logic [3:0] DATA_BITS = 4'h8;

  // Readiness delay after reset release, in states (one state per clock)
  localparam int unsigned READY_STATES = 100;
  localparam logic [7:0] READY_CYCLES = 8'(READY_STATES);

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field positions in the status word
  localparam int unsigned ST_BOOT_BIT = 0;
  localparam int unsigned ST_USER_BIT = 1;
  localparam int unsigned ST_PROG_EN_BIT = 2;
  localparam int unsigned ST_STATE_LSB = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SETTLE = 4'h1,
    ST_WAIT_LOW = 4'h2,
    ST_TIME_LOW = 4'h3,
    ST_DIVIDE = 4'h4,
    ST_SEND_ACK = 4'h5,
    ST_WAIT_CONFIRM = 4'h6,
    ST_ERASE = 4'h7,
    ST_LEN_HI = 4'h8,
    ST_LEN_LO = 4'h9,
    ST_LOAD = 4'hA,
    ST_BRANCH = 4'hB,
    ST_RUN = 4'hC
  } fbl_state_t;
endpackage

// >>> core/fbl_ram.sv
// On-chip program RAM: byte wide, synchronous write, registered read
`timescale 1ns/1ps
module fbl_ram #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // No reset on the array; read data is a plain register
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// >>> core/fbl_uart.sv
// Asynchronous serial channel: 8 data bits, 1 stop bit, no parity, runtime bit divisor
`timescale 1ns/1ps
module fbl_uart #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic [DIV_W-1:0] bitCycles,
  input wire logic rxOn,
  input wire logic txOn,
  input wire logic rxLine,
  input wire logic txStart,
  input wire logic [7:0] txByte,
  output logic txLine,
  output logic txBusy,
  output logic rxValid,
  output logic [7:0] rxByte
);
  import fbl_pkg::*;
  logic [DIV_W-1:0] rxCnt_q, txCnt_q;
  logic [3:0] rxBit_q, txBit_q;
  logic rxBusy_q;
  logic [8:0] txSh_q;
  logic rxTick, txTick;

  assign rxTick = (rxCnt_q == '0);
  assign txTick = (txCnt_q == '0);

  // Receiver: first sample lands mid start bit, then one per bit period
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxBusy_q <= 1'b0;
      rxCnt_q <= '0;
      rxBit_q <= 4'h0;
      rxByte <= 8'h00;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!rxOn) begin
        rxBusy_q <= 1'b0;
      end else if (!rxBusy_q) begin
        if (!rxLine) begin
          rxBusy_q <= 1'b1;
          rxCnt_q <= bitCycles >> 1;
          rxBit_q <= 4'h0;
        end
      end else if (!rxTick) begin
        rxCnt_q <= rxCnt_q - 1'b1;
      end else begin
        rxCnt_q <= bitCycles - 1'b1;
        rxBit_q <= rxBit_q + 1'b1;
        if (rxBit_q == 4'h0 && rxLine) begin
          rxBusy_q <= 1'b0; // Glitch, not a start bit
        end else if (rxBit_q == DATA_BITS + 4'h1) begin
          rxBusy_q <= 1'b0;
          rxValid <= rxLine; // Framing error drops the byte
        end else if (rxBit_q != 4'h0) begin
          rxByte <= {rxLine, rxByte[7:1]}; // LSB first
        end
      end
    end
  end

  // Transmitter: start bit, eight data bits, stop bit; idle line high
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      txBusy <= 1'b0;
      txLine <= 1'b1;
      txCnt_q <= '0;
      txBit_q <= 4'h0;
      txSh_q <= 9'h1FF;
    end else if (!txBusy) begin
      txLine <= 1'b1;
      if (txStart && txOn) begin
        txBusy <= 1'b1;
        txLine <= 1'b0;
        txSh_q <= {1'b1, txByte}; // 8N1 frame
        txCnt_q <= bitCycles - 1'b1;
        txBit_q <= 4'h0;
      end
    end else if (!txTick) begin
      txCnt_q <= txCnt_q - 1'b1;
    end else if (txBit_q == DATA_BITS + 4'h1) begin
      txBusy <= 1'b0;
    end else begin
      txCnt_q <= bitCycles - 1'b1;
      txBit_q <= txBit_q + 1'b1;
      txLine <= txSh_q[0];
      txSh_q <= {1'b1, txSh_q[8:1]};
    end
  end
endmodule

// >>> core/fbl_loader.sv
// Boot-mode loader: mode latch, autobaud, handshake, erase, program load and branch
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module fbl_loader #(
  parameter int unsigned RAM_AW = 12,
  parameter int unsigned DIV_W = 16,
  parameter int unsigned LOW_W = 20
) (
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [2:0] mode_select_pins,
  input wire logic flash_write_enable_pin,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic serial_transmit_pin_oe,
  // System side
  input wire logic watchdogReset,
  input wire logic flashBlank,
  input wire logic eraseDone,
  output logic eraseAllReq,
  output logic [7:0] eraseBlockReq,
  output logic flashProgEnable,
  output logic branchValid,
  output logic [19:0] branchAddr,
  input wire logic [RAM_AW-1:0] ramRdAddr,
  output logic [7:0] ramRdData
);
  import fbl_pkg::*;

  logic rstSync1_q, rstN_q;
  logic [2:0] mdSync1_q, mdSync_q;
  logic fweSync1_q, fweSync_q, rxSync1_q, rxSync_q;
  logic latched_q, bootMode_q, userMode_q;
  fbl_state_t state_q, state_d;
  logic [7:0] settleCnt_q;
  logic [LOW_W-1:0] lowCnt_q;
  logic [DIV_W-1:0] baud_q;
  logic rxOn_q, txOn_q, txStart_q;
  logic [15:0] loadLen_q, loadCnt_q;
  logic [RAM_AW-1:0] ramWrAddr;
  logic ramWrEn;
  logic txLine, txBusy, rxValid;
  logic [7:0] rxByte;
  logic bootPins, userPins;

  // Reset release through two flops; pins through two flops before use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN_q <= rstSync1_q;
    end
  end

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      mdSync1_q <= 3'h0;
      mdSync_q <= 3'h0;
      fweSync1_q <= 1'b0;
      fweSync_q <= 1'b0;
      rxSync1_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      mdSync1_q <= mode_select_pins;
      mdSync_q <= mdSync1_q;
      fweSync1_q <= flash_write_enable_pin;
      fweSync_q <= fweSync1_q;
      rxSync1_q <= serial_receive_pin;
      rxSync_q <= rxSync1_q;
    end
  end

  // Mode decode: boot and user program each from mode 5 or 7
  assign bootPins = fweSync_q && (mdSync_q == MODE_BOOT5 || mdSync_q == MODE_BOOT7);
  assign userPins = fweSync_q && (mdSync_q == MODE_USER5 || mdSync_q == MODE_USER7);

  // Captured once after release; only a pin reset clears it, so watchdog restarts keep it
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      latched_q <= 1'b0;
      bootMode_q <= 1'b0;
      userMode_q <= 1'b0;
    end else if (!latched_q && rstSync1_q) begin
      // Sync flops need two more edges; wait until they carry post-release pin levels
      latched_q <= (settleCnt_q == 8'h02);
      bootMode_q <= bootPins;
      userMode_q <= userPins && !bootPins;
    end
  end

  // Next state of the boot sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (latched_q && bootMode_q) state_d = ST_SETTLE;
      ST_SETTLE: if (settleCnt_q == READY_CYCLES) state_d = ST_WAIT_LOW;
      ST_WAIT_LOW: if (!rxSync_q) state_d = ST_TIME_LOW;
      ST_TIME_LOW: if (rxSync_q) state_d = ST_DIVIDE;
      ST_DIVIDE: if (lowCnt_q < LOW_W'(LOW_BITS)) state_d = ST_SEND_ACK;
      ST_SEND_ACK: if (txStart_q) state_d = ST_WAIT_CONFIRM;
      ST_WAIT_CONFIRM: if (rxValid && rxByte == BYTE_CONFIRM) state_d = ST_ERASE;
      ST_ERASE: if (flashBlank || eraseDone) state_d = ST_LEN_HI;
      ST_LEN_HI: if (rxValid) state_d = ST_LEN_LO;
      ST_LEN_LO: if (rxValid) state_d = ST_LOAD;
      ST_LOAD: if (loadCnt_q == loadLen_q && !txBusy) state_d = ST_BRANCH;
      ST_BRANCH: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register; a watchdog reset reruns the built-in loader from the top
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      state_q <= ST_IDLE;
    end else if (watchdogReset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Settle counter also paces the mode capture right after release
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      settleCnt_q <= 8'h00;
    end else if (watchdogReset || state_q == ST_WAIT_LOW) begin
      settleCnt_q <= 8'h00;
    end else if (settleCnt_q != READY_CYCLES) begin
      settleCnt_q <= settleCnt_q + 8'h01;
    end
  end

  // Low time of a zero byte spans nine bits; divide by repeated subtraction
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      lowCnt_q <= '0;
      baud_q <= '1;
    end else if (state_q == ST_WAIT_LOW) begin
      lowCnt_q <= '0;
      baud_q <= '0;
    end else if (state_q == ST_TIME_LOW && lowCnt_q != '1) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end else if (state_q == ST_DIVIDE && lowCnt_q >= LOW_W'(LOW_BITS)) begin
      lowCnt_q <= lowCnt_q - LOW_W'(LOW_BITS);
      baud_q <= baud_q + 1'b1; // Divisor survives the branch
    end
  end

  // Serial enables, ack strobe and load counters
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      rxOn_q <= 1'b0;
      txOn_q <= 1'b0;
      txStart_q <= 1'b0;
      loadLen_q <= 16'h0000;
      loadCnt_q <= 16'h0000;
    end else begin
      txStart_q <= (state_q == ST_SEND_ACK) && !txStart_q && !txBusy; // Exactly one zero byte
      if (state_q == ST_DIVIDE && state_d == ST_SEND_ACK) begin
        rxOn_q <= 1'b1;
        txOn_q <= 1'b1;
      end else if (state_q == ST_BRANCH || state_q == ST_IDLE) begin
        rxOn_q <= 1'b0;
        txOn_q <= 1'b0;
      end
      if (state_q == ST_LEN_HI && rxValid) begin
        loadLen_q <= {rxByte, 8'h00};
        loadCnt_q <= 16'h0000;
      end else if (state_q == ST_LEN_LO && rxValid) begin
        loadLen_q <= {loadLen_q[15:8], rxByte};
      end else if (ramWrEn) begin
        loadCnt_q <= loadCnt_q + 16'h0001;
      end
    end
  end

  // Every loaded byte lands in program RAM in arrival order
  assign ramWrEn = (state_q == ST_LOAD) && rxValid && (loadCnt_q != loadLen_q);
  assign ramWrAddr = loadCnt_q[RAM_AW-1:0];

  // Erase, branch and program enable; user mode gets block-wise erase only
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      eraseAllReq <= 1'b0;
      flashProgEnable <= 1'b0;
      branchValid <= 1'b0;
      branchAddr <= 20'h00000;
    end else begin
      eraseAllReq <= (state_q == ST_ERASE) && !flashBlank && !eraseDone;
      branchValid <= (state_q == ST_BRANCH);
      if (state_q == ST_BRANCH) begin
        branchAddr <= RAM_START_ADDR;
      end
      if (watchdogReset) begin
        flashProgEnable <= 1'b0;
      end else if (state_q == ST_BRANCH) begin
        flashProgEnable <= 1'b1;
      end else if (latched_q && userMode_q) begin
        flashProgEnable <= fweSync_q;
      end
    end
  end

  // Transmit pin driven high as an output once the loader owns it
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      serial_transmit_pin <= 1'b1;
      serial_transmit_pin_oe <= 1'b0;
    end else begin
      serial_transmit_pin <= txOn_q ? txLine : 1'b1;
      serial_transmit_pin_oe <= serial_transmit_pin_oe || txOn_q;
    end
  end

  fbl_uart #(.DIV_W(DIV_W)) uart (
    .mclk(mclk),
    .rstN(rstN_q),
    .bitCycles(baud_q),
    .rxOn(rxOn_q),
    .txOn(txOn_q),
    .rxLine(rxSync_q),
    .txStart(txStart_q),
    .txByte(BYTE_ZERO),
    .txLine(txLine),
    .txBusy(txBusy),
    .rxValid(rxValid),
    .rxByte(rxByte)
  );

  fbl_ram #(.ADDR_W(RAM_AW)) ram (
    .mclk(mclk),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(rxByte),
    .rdAddr(ramRdAddr),
    .rdData(ramRdData)
  );

  // AXI4-Lite: address and data taken in either order, response once both held
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite, wrHit, rdHit;
  logic [31:0] rdWord;

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrHit = (awAddr_q == REG_ERASE_BLK);
  assign rdHit = (s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_BAUD) ||
                 (s_axi_araddr == REG_ERASE_BLK) || (s_axi_araddr == REG_SERIAL_CTRL) ||
                 (s_axi_araddr == REG_LOAD_COUNT);
  assign rdWord = (s_axi_araddr == REG_STATUS) ? {24'h000000, state_q, 1'b0, flashProgEnable,
                                                  userMode_q, bootMode_q} :
                  (s_axi_araddr == REG_BAUD) ? {{(32-DIV_W){1'b0}}, baud_q} :
                  (s_axi_araddr == REG_SERIAL_CTRL) ? {30'h00000000, txOn_q, rxOn_q} :
                  (s_axi_araddr == REG_LOAD_COUNT) ? {loadLen_q, loadCnt_q} : 32'h00000000;

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      eraseBlockReq <= 8'h00;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      eraseBlockReq <= 8'h00;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
        if (wrHit && wStrb_q[0] && userMode_q && fweSync_q) begin
          eraseBlockReq <= wData_q[7:0]; // Block-granular erase in user mode
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1; // Ready again once the response is gone
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read answer registered one cycle after the address is taken
  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// >>> tb/fbl_loader_asserts.sv
// Checker on the loader top ports, bound into every loader instance
`timescale 1ns/1ps
module fbl_loader_chk import fbl_pkg::*; #(
  parameter int unsigned RAM_AW = 12,
  parameter int unsigned DIV_W = 16,
  parameter int unsigned LOW_W = 20
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] mode_select_pins,
  input wire logic flashBlank,
  input wire logic watchdogReset,
  input wire logic eraseDone,
  input wire logic eraseAllReq,
  input wire logic [7:0] eraseBlockReq,
  input wire logic flashProgEnable,
  input wire logic branchValid,
  input wire logic [19:0] branchAddr,
  input wire logic serial_transmit_pin,
  input wire logic serial_transmit_pin_oe
);
  logic [1:0] txFalls_q;
  logic [7:0] sinceRst_q;
  logic txPrev_q;
  // Count start bits sent; a watchdog restart legitimately allows a fresh ack
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txFalls_q <= 2'h0;
      txPrev_q <= 1'b1;
      sinceRst_q <= 8'h00;
    end else begin
      txPrev_q <= serial_transmit_pin;
      if (watchdogReset)
        txFalls_q <= 2'h0;
      else if (txPrev_q && !serial_transmit_pin && txFalls_q != 2'h3)
        txFalls_q <= txFalls_q + 2'h1;
      if (sinceRst_q != 8'hFF)
        sinceRst_q <= sinceRst_q + 8'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_branch_target: assert property (branchValid |-> branchAddr == RAM_START_ADDR)
    else $error("branch target wrong");
  chk_branch_pulse: assert property (branchValid |=> !branchValid)
    else $error("branch pulse too long");
  chk_branch_prog: assert property (branchValid |-> ##[0:1] flashProgEnable)
    else $error("programming not enabled at branch");
  chk_tx_parked: assert property (branchValid |-> (serial_transmit_pin && serial_transmit_pin_oe) [*8])
    else $error("transmit pin not parked high");
  chk_erase_blank: assert property ($rose(eraseAllReq) |-> !flashBlank)
    else $error("erase started on blank flash");
  chk_erase_hold: assert property (eraseAllReq && !eraseDone && !watchdogReset |=> eraseAllReq)
    else $error("erase request dropped early");
  chk_block_user: assert property (eraseBlockReq != 8'h00 |-> !eraseAllReq && flashProgEnable)
    else $error("block erase outside user programming");
  chk_block_pulse: assert property (eraseBlockReq != 8'h00 |=> eraseBlockReq == 8'h00)
    else $error("block erase held");
  chk_ack_once: assert property (txFalls_q <= 2'h1)
    else $error("more than one ack byte");
  chk_settle_quiet: assert property (sinceRst_q < 8'h64 |-> serial_transmit_pin)
    else $error("transmit active while settling");
  chk_wd_prog_off: assert property (watchdogReset |=> !flashProgEnable)
    else $error("programming left enabled after restart");
  chk_mode6_quiet: assert property (mode_select_pins == 3'h6 |-> eraseBlockReq == 8'h00 && !eraseAllReq)
    else $error("erase in mode six");
endmodule

bind fbl_loader fbl_loader_chk #(.RAM_AW(RAM_AW), .DIV_W(DIV_W), .LOW_W(LOW_W)) u_chk (
  .mclk(mclk), .resetn(resetn), .mode_select_pins(mode_select_pins), .flashBlank(flashBlank),
  .watchdogReset(watchdogReset), .eraseDone(eraseDone), .eraseAllReq(eraseAllReq),
  .eraseBlockReq(eraseBlockReq), .flashProgEnable(flashProgEnable), .branchValid(branchValid),
  .branchAddr(branchAddr), .serial_transmit_pin(serial_transmit_pin),
  .serial_transmit_pin_oe(serial_transmit_pin_oe));

// >>> tb/fbl_host_model.sv
// Behavioural host on the far side of the serial link
`timescale 1ns/1ps
module fbl_host_model #(
  parameter int unsigned BIT_CYCLES = 50
) (
  input wire logic mclk,
  output logic rxLine,
  input wire logic txLine
);
  // Pulled-up line sits high, also through reset
  initial rxLine = 1'b1;
  // 8N1, LSB first; bit time scaled down from the 4800/9600 rates to keep runs short
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (BIT_CYCLES) @(posedge mclk);
    end
  endtask
  // Mid-bit sampling on the falling edge, so registered outputs have settled
  task automatic recvByte(output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    ok = 1'b0;
    n = 0;
    while (txLine !== 1'b0 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n < 20000) begin
      repeat (BIT_CYCLES / 2) @(negedge mclk);
      ok = (txLine === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(negedge mclk);
        b[i] = txLine;
      end
      repeat (BIT_CYCLES) @(negedge mclk);
      ok = ok && (txLine === 1'b1);
    end
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench: boot handshake and load, watchdog restart, user mode, mode six
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb;
  import fbl_pkg::*;
  localparam int unsigned BITC = 50;
  logic mclk, resetn, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [7:0] awAddr, arAddr, eraseBlockReq, ramData, blkLast;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [2:0] modePins;
  logic fwePin, rxLine, txLine, txOe, wdReset, flashBlank, eraseDone, eraseAllReq, progEn, branchValid;
  logic [19:0] branchAddr;
  logic [11:0] ramAddr;
  int errors, total_checks, branchCount, blkCount;
  logic [7:0] prog [3] = '{8'hA1, 8'h5C, 8'h3E};

  fbl_loader dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .mode_select_pins(modePins),
    .flash_write_enable_pin(fwePin), .serial_receive_pin(rxLine), .serial_transmit_pin(txLine),
    .serial_transmit_pin_oe(txOe), .watchdogReset(wdReset), .flashBlank(flashBlank),
    .eraseDone(eraseDone), .eraseAllReq(eraseAllReq), .eraseBlockReq(eraseBlockReq),
    .flashProgEnable(progEn), .branchValid(branchValid), .branchAddr(branchAddr),
    .ramRdAddr(ramAddr), .ramRdData(ramData));
  fbl_host_model #(.BIT_CYCLES(BITC)) host (.mclk(mclk), .rxLine(rxLine), .txLine(txLine));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Count one-cycle pulses away from the launching edge
  always @(negedge mclk) begin
    if (branchValid === 1'b1)
      branchCount++;
    if (eraseBlockReq !== 8'h00) begin
      blkCount++;
      blkLast = eraseBlockReq;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic giveUp();
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask
  // Pins move only while reset is low, held 20 clocks
  task automatic applyReset(input logic [2:0] m, input logic f);
    resetn <= 1'b0;
    modePins <= m;
    fwePin <= f;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  // Ready sampled 1 ns after an edge holds until the next edge, where the transfer happens
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, wv, done;
    awAddr <= a;
    wData <= d;
    wStrb <= 4'hF;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done) begin
      #1;
      aw = awValid && awReady;
      wv = wValid && wReady;
      done = bValid;
      r = bResp;
      @(posedge mclk);
      if (aw) awValid <= 1'b0;
      if (wv) wValid <= 1'b0;
      if (done) bReady <= 1'b0;
      n++;
      if (n > 100) giveUp();
    end
    @(posedge mclk);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic tk, done;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done) begin
      #1;
      tk = arValid && arReady;
      done = rValid;
      d = rData;
      r = rResp;
      @(posedge mclk);
      if (tk) arValid <= 1'b0;
      if (done) rReady <= 1'b0;
      n++;
      if (n > 100) giveUp();
    end
    @(posedge mclk);
  endtask

  task automatic testBoot();
    logic [7:0] b;
    logic ok;
    logic [31:0] d, baud;
    logic [1:0] r;
    int n;
    applyReset(MODE_BOOT5, 1'b1);
    repeat (100) @(posedge mclk);
    host.sendByte(BYTE_ZERO);
    host.recvByte(b, ok);
    `CHK(ok, 1'b1)
    `CHK(b, BYTE_ZERO)
    @(posedge mclk);
    axiRead(REG_BAUD, baud, r);
    `CHK(baud >= BITC - 1 && baud <= BITC, 1'b1)
    axiRead(REG_STATUS, d, r);
    `CHK(d[1:0], 2'b01)
    host.sendByte(BYTE_CONFIRM);
    for (n = 0; n < 1000 && eraseAllReq !== 1'b1; n++) @(posedge mclk);
    `CHK(eraseAllReq, 1'b1)
    eraseDone <= 1'b1; // No interrupts modelled during erase
    @(posedge mclk);
    eraseDone <= 1'b0;
    // Short program at address zero, well clear of the emulation window
    host.sendByte(8'h00);
    host.sendByte(8'h03);
    for (int i = 0; i < 3; i++) host.sendByte(prog[i]);
    for (n = 0; n < 2000 && branchCount == 0; n++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    `CHK(branchCount, 1)
    `CHK(branchAddr, RAM_START_ADDR)
    `CHK(progEn, 1'b1)
    `CHK({txLine, txOe}, 2'b11)
    axiRead(REG_SERIAL_CTRL, d, r);
    `CHK(d[1:0], 2'b00)
    axiRead(REG_BAUD, d, r);
    `CHK(d, baud)
    for (int i = 0; i < 3; i++) begin
      ramAddr <= 12'(i);
      repeat (2) @(posedge mclk);
      `CHK(ramData, prog[i])
    end
    $display("boot test done, %0d checks", total_checks);
  endtask
  // Pins deliberately read user mode: the restart must ignore them
  task automatic testWatchdog();
    logic [7:0] b;
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    modePins <= MODE_USER5;
    wdReset <= 1'b1;
    @(posedge mclk);
    wdReset <= 1'b0;
    repeat (110) @(posedge mclk);
    `CHK(progEn, 1'b0)
    axiRead(REG_STATUS, d, r);
    `CHK(d[1:0], 2'b01)
    host.sendByte(BYTE_ZERO);
    host.recvByte(b, ok);
    `CHK({ok, b}, {1'b1, BYTE_ZERO})
    @(posedge mclk);
    $display("watchdog test done, %0d checks", total_checks);
  endtask
  task automatic testUser();
    logic [31:0] d;
    logic [1:0] r;
    applyReset(MODE_USER7, 1'b1);
    axiRead(REG_STATUS, d, r);
    `CHK(d[2:0], 3'b110)
    axiWrite(REG_ERASE_BLK, 32'h00000005, r);
    repeat (3) @(posedge mclk);
    `CHK({r, blkCount[7:0], blkLast, eraseAllReq}, {RESP_OKAY, 8'h01, 8'h05, 1'b0})
    axiWrite(REG_STATUS, 32'h00000001, r);
    `CHK(r, RESP_SLVERR)
    axiRead(8'h20, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h00000000})
    fwePin <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(progEn, 1'b0)
    axiWrite(REG_ERASE_BLK, 32'h00000003, r);
    repeat (3) @(posedge mclk);
    `CHK(blkCount, 1)
    applyReset(3'h6, 1'b0);
    axiRead(REG_STATUS, d, r);
    `CHK(d[2:0], 3'b000)
    axiWrite(REG_ERASE_BLK, 32'h000000FF, r);
    repeat (3) @(posedge mclk);
    `CHK(blkCount, 1)
    $display("user test done, %0d checks", total_checks);
  endtask

  initial begin
    resetn = 1'b0;
    modePins = MODE_BOOT5;
    fwePin = 1'b1;
    {awValid, wValid, bReady, arValid, rReady, wdReset, flashBlank, eraseDone} = 8'h00;
    {awAddr, arAddr, wData, wStrb, ramAddr} = '0;
    errors = 0;
    total_checks = 0;
    branchCount = 0;
    blkCount = 0;
    blkLast = 8'h00;
    @(posedge mclk);
    testBoot();
    testWatchdog();
    testUser();
    tally_and_finish();
  end
endmodule
